// file: dct_2d_transform_core_test.sv
`timescale 1ns/1ps
module dct_2d_transform_core_test
  import dctc_pkg::*;
  ;
  // ==========================================================
  // Signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pixel_bus_oe, pixel_block_strobe_n_out, pixel_block_strobe_n_oe;
  logic coef_bus_oe, coef_block_strobe_n_out, coef_block_strobe_n_oe, pstb_w, cstb_w, m_stb_n;
  logic [8:0] pixel_bus_out, pix_w;
  logic [11:0] coef_bus_out, coef_w, m_item;
  logic signed [31:0] g_item;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int left = 0;
  int sq[$];
  int lq[$];
  logic [31:0] rq[$];
  logic dph_q = 1'b0;
  logic live = 1'b0;
  logic no_lat = 1'b0;
  logic fwd_m = 1'b1;
  int mn_m = 16;
  logic [7:0] lf = 8'h5F;
  int mn_tab[7] = '{256, 32, 128, 16, 128, 32, 64};
  always #12.5 hclk = ~hclk;
  assign pix_w = pixel_bus_oe ? pixel_bus_out : m_item[8:0];
  assign pstb_w = pixel_block_strobe_n_oe ? pixel_block_strobe_n_out : m_stb_n;
  assign coef_w = coef_bus_oe ? coef_bus_out : m_item;
  assign cstb_w = coef_block_strobe_n_oe ? coef_block_strobe_n_out : m_stb_n;
  dctc_core dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pixel_bus_in(pix_w),
    .pixel_bus_out(pixel_bus_out), .pixel_bus_oe(pixel_bus_oe),
    .pixel_block_strobe_n_in(pstb_w), .pixel_block_strobe_n_out(pixel_block_strobe_n_out),
    .pixel_block_strobe_n_oe(pixel_block_strobe_n_oe), .coef_bus_in(coef_w),
    .coef_bus_out(coef_bus_out), .coef_bus_oe(coef_bus_oe), .coef_block_strobe_n_in(cstb_w),
    .coef_block_strobe_n_out(coef_block_strobe_n_out),
    .coef_block_strobe_n_oe(coef_block_strobe_n_oe)
  );
  dctc_feed_model m (.hclk(hclk), .item(m_item), .stb_n(m_stb_n));

  // ==========================================================
  // Helpers
  task automatic wrap_up;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic signed [31:0] e,
                     input logic signed [31:0] g, input int tol);
    samples_checked++;
    if ($isunknown(g) || g - e > tol || e - g > tol) begin
      errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int rnd(input real r);
    return (r < 0) ? -$rtoi(0.5 - r) : $rtoi(r + 0.5);
  endfunction
  function automatic int expv(input int kind, input int k, input int v, input logic rng);
    int c;
    int lo;
    lo = rng ? 0 : -256;
    if (kind == 2) begin
      c = rnd(v / 8.0);
      return (c > 255) ? 255 : (c < lo) ? lo : c;
    end
    if (kind == 1) begin
      return (k < 4) ? rnd((k == 0 ? 2.0 : 4.0) * v * $cos(k * 3.14159265 / 8)) : 0;
    end
    c = rng ? v : (v > 127) ? 127 : (v < -128) ? -128 : v;
    return (k == 0) ? 8 * c : 0;
  endfunction
  function automatic logic [31:0] cfg_w(input logic fw, input logic [2:0] c, input logic rng,
                                        input logic fz);
    logic [31:0] w;
    w = 32'h0;
    w[DCTC_FWD_BIT] = fw;
    w[DCTC_BSIZE_LSB +: 3] = c;
    w[DCTC_RANGE_BIT] = rng;
    w[DCTC_FREEZE_BIT] = fz;
    return w;
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask

  // ==========================================================
  // Output watcher and timeout
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 40000) begin
      errors++;
      wrap_up();
    end
    if (dph_q && hreadyout) begin
      chk("hrdata", rq.pop_front(), hrdata, 0);
      chk("hresp", 0, hresp, 0);
    end
    dph_q <= hsel && htrans[1] && hreadyout && !hwrite;
    if (live) begin
      if ((fwd_m ? pstb_w : cstb_w) === 1'b0) lq.push_back(cyc + DCTC_LAT_BASE + mn_m);
      if ((fwd_m ? coef_block_strobe_n_out : pixel_block_strobe_n_out) === 1'b0) begin
        if (!no_lat) chk("latency", lq[0], cyc, 0);
        void'(lq.pop_front());
        chk("coef_oe", fwd_m, coef_bus_oe, 0);
        chk("pix_oe", !fwd_m, pixel_bus_oe, 0);
        chk("stb_oe", fwd_m, coef_block_strobe_n_oe, 0);
        left = mn_m;
      end
      if (left > 0) begin
        g_item = fwd_m ? $signed(coef_bus_out) : $signed(pixel_bus_out);
        chk("item", sq.pop_front(), g_item, 1);
        left--;
      end
    end
  end

  // ==========================================================
  // Block runs
  task automatic run(input logic fw, input logic [2:0] code, input logic rng, input int kind,
                     input int v, input int nb, input logic frz);
    int blk[$];
    logic [12:0] g0;
    live = 1'b0;
    ahb(1'b1, DCTC_CTRL_OFS, cfg_w(fw, code, rng, 1'b0));
    rd(DCTC_CTRL_OFS, cfg_w(fw, code, rng, 1'b0));
    fwd_m = fw;
    mn_m = mn_tab[code];
    no_lat = frz;
    lq = {};
    repeat (400) @(posedge hclk);
    live = 1'b1;
    for (int b = 0; b < nb; b++) begin
      for (int k = 0; k < mn_m; k++) begin
        blk.push_back((kind == 2 && k > 0) || (kind == 1 && k > 3) ? 0 : v + 5 * b);
        sq.push_back(expv(kind, k, v + 5 * b, rng));
      end
    end
    m.send(blk, mn_m);
    if (frz) begin
      repeat (140) @(posedge hclk);
      ahb(1'b1, DCTC_CTRL_OFS, cfg_w(fw, code, rng, 1'b1));
      @(negedge hclk);
      g0 = {coef_block_strobe_n_out, coef_bus_out};
      repeat (20) @(negedge hclk);
      chk("frozen", g0, {coef_block_strobe_n_out, coef_bus_out}, 0);
      ahb(1'b1, DCTC_CTRL_OFS, cfg_w(fw, code, rng, 1'b0));
    end
    while (sq.size() > 0) @(posedge hclk);
    $display("test fwd=%0d size=%0d kind=%0d done", fw, code, kind);
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(DCTC_CTRL_OFS, 32'h0000000D);
    rd(8'h40, 32'h0);
    for (int c = 0; c < 7; c++) begin
      lf = lfsr(lf);
      run(1'b1, 3'(c), 1'b0, 0, int'(lf[6:0]) - 64, 1, 1'b0);
    end
    run(1'b1, 3'h3, 1'b0, 0, 200, 2, 1'b0);
    run(1'b1, 3'h3, 1'b0, 0, -200, 1, 1'b0);
    run(1'b1, 3'h3, 1'b1, 0, 200, 1, 1'b0);
    run(1'b1, 3'h3, 1'b0, 1, int'(lf[5:0]), 1, 1'b0);
    run(1'b0, 3'h3, 1'b0, 2, 80, 2, 1'b0);
    run(1'b0, 3'h6, 1'b1, 2, -80, 1, 1'b0);
    run(1'b0, 3'h5, 1'b1, 2, 2047, 1, 1'b0);
    run(1'b0, 3'h3, 1'b0, 2, -2048, 1, 1'b0);
    run(1'b1, 3'h3, 1'b0, 0, 10, 1, 1'b1);
    wrap_up();
  end
endmodule

// file: dctc_core.sv
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Forward takes pixels, drives coefficients; inverse the reverse.
// [RULE_02] Coefficients are 12-bit two's complement, -2048 to 2047.
// [RULE_03] Pixels are 9-bit two's complement in both directions.
// [RULE_04] Seven block geometries from 16x16 down to 4x4.
// [RULE_05] Output block is the transpose of the input block.
// [RULE_06] Forward scales by 32/(MN) with halved DC terms; inverse by 1/8.
// [RULE_07] Feeder may use any of eight scan orders.
// [RULE_08] Unsigned pixels: sign bit zero, range select one both ways.
// [RULE_09] Unsigned mode saturates inverse output pixels to 0..255.
// [RULE_10] Signed 8-bit mode clips forward input to -128..127.
// [RULE_11] Full 9-bit mode: no clipping, overflow possible.
// [RULE_12] One item per clock in and out.
// [RULE_13] Output item and strobe follow input by 130 plus MN clocks.
// [RULE_14] Active-low strobe marks first item; direction swaps with mode.
// [RULE_15] Block size codes map to seven sizes; code 111 reserved.
// [RULE_16] High selects forward; freeze holds all internal state.
module dctc_core
  import dctc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [8:0] pixel_bus_in,
  output logic [8:0] pixel_bus_out,
  output logic pixel_bus_oe,
  input wire logic pixel_block_strobe_n_in,
  output logic pixel_block_strobe_n_out,
  output logic pixel_block_strobe_n_oe,
  input wire logic [11:0] coef_bus_in,
  output logic [11:0] coef_bus_out,
  output logic coef_bus_oe,
  input wire logic coef_block_strobe_n_in,
  output logic coef_block_strobe_n_out,
  output logic coef_block_strobe_n_oe
);

  // ==========================================================
  // Bus slave
  dctc_cfg_t cfg_q;
  dctc_cfg_t rd_cfg;
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic bus_acc;
  logic [31:0] rd_word;
  logic [7:0] p1_q;
  logic s2_run_q;
  logic ser_run_q;

  assign bus_acc = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_pend_q <= bus_acc && hwrite;
      if (bus_acc) begin
        waddr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= DCTC_CFG_RST;
    end else if (wr_pend_q && waddr_q == DCTC_CTRL_OFS) begin
      cfg_q <= dctc_ctrl_unpack(hwdata);
    end
  end

  // Forward a write in flight so a following read sees it
  always_comb begin
    rd_cfg = (wr_pend_q && waddr_q == DCTC_CTRL_OFS) ? dctc_ctrl_unpack(hwdata) : cfg_q;
    rd_word = 32'h0000_0000;
    if (haddr[7:0] == DCTC_CTRL_OFS) begin
      rd_word[DCTC_FWD_BIT] = rd_cfg.fwd;
      rd_word[DCTC_BSIZE_LSB +: 3] = rd_cfg.bsize;
      rd_word[DCTC_RANGE_BIT] = rd_cfg.range_sel;
      rd_word[DCTC_FREEZE_BIT] = rd_cfg.freeze;
    end else if (haddr[7:0] == DCTC_STAT_OFS) begin
      rd_word[DCTC_ST_POS_LSB +: 8] = p1_q;
      rd_word[DCTC_ST_S2_BIT] = s2_run_q;
      rd_word[DCTC_ST_OUT_BIT] = ser_run_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (bus_acc && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Geometry and input capture
  dctc_geom_t geo;
  logic run;
  logic [2:0] l1;
  logic [2:0] l2;
  logic [8:0] mn;
  logic [7:0] mn_m1;
  logic [3:0] l1_m1;
  logic [3:0] l2_m1;
  logic signed [11:0] in_sel;
  logic stb_sel;
  logic signed [11:0] in_q;
  logic stb_q;

  assign geo = dctc_geom(cfg_q.bsize); // [RULE_04] [RULE_15]
  assign run = ~cfg_q.freeze; // [RULE_16]
  assign l1 = cfg_q.fwd ? geo.lm : geo.ln;
  assign l2 = cfg_q.fwd ? geo.ln : geo.lm;
  assign mn = 9'h001 << ({1'b0, geo.lm} + {1'b0, geo.ln});
  assign mn_m1 = 8'(mn - 9'h001);
  assign l1_m1 = 4'((5'h01 << l1) - 5'h01);
  assign l2_m1 = 4'((5'h01 << l2) - 5'h01);

  always_comb begin
    in_sel = 12'sh000;
    stb_sel = 1'b0;
    if (cfg_q.fwd) begin // [RULE_01]
      stb_sel = ~pixel_block_strobe_n_in; // [RULE_14]
      in_sel = 12'($signed(pixel_bus_in)); // [RULE_03] [RULE_11]
      if (!cfg_q.range_sel && $signed(pixel_bus_in) < DCTC_SCLIP_LO) begin
        in_sel = 12'(DCTC_SCLIP_LO); // [RULE_10]
      end else if (!cfg_q.range_sel && $signed(pixel_bus_in) > DCTC_SCLIP_HI) begin
        in_sel = 12'(DCTC_SCLIP_HI); // [RULE_10]
      end
    end else begin
      stb_sel = ~coef_block_strobe_n_in; // [RULE_14]
      in_sel = $signed(coef_bus_in); // [RULE_02]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q <= 12'sh000;
      stb_q <= 1'b0;
      p1_q <= 8'h00;
    end else if (run) begin
      in_q <= in_sel;
      stb_q <= stb_sel;
      p1_q <= (stb_sel || p1_q == mn_m1) ? 8'h00 : p1_q + 8'h01; // [RULE_12]
    end
  end

  // ==========================================================
  // First pass: one accumulator per output index
  logic [3:0] idx1;
  logic [3:0] col1;
  logic wb_q;
  logic signed [29:0] acc1_q [16];
  logic signed [29:0] sum1 [16];
  logic signed [20:0] tmem [512];

  assign idx1 = p1_q[3:0] & l1_m1;
  assign col1 = 4'(p1_q >> l1);

  for (genvar a = 0; a < 16; a++) begin : g_s1
    logic signed [13:0] c;
    logic signed [25:0] prod;
    assign c = dctc_cos(dctc_ang(cfg_q.fwd, 4'(a), idx1, l1));
    assign prod = in_q * c;
    assign sum1[a] = (idx1 == 4'h0 ? 30'sh0 : acc1_q[a]) + 30'(prod);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int a = 0; a < 16; a++) acc1_q[a] <= 30'sh0;
      wb_q <= 1'b0;
    end else if (run) begin
      for (int a = 0; a < 16; a++) acc1_q[a] <= sum1[a];
      if (p1_q == mn_m1) begin
        wb_q <= ~wb_q;
      end
    end
  end

  // Column results stored by [index][column]; second pass reads rows
  always_ff @(posedge hclk) begin
    if (run && idx1 == l1_m1) begin
      for (int a = 0; a < 16; a++) begin
        tmem[{wb_q, 4'(a), col1}] <= 21'(sum1[a] >>> DCTC_T_SHIFT); // [RULE_05]
      end
    end
  end

  // ==========================================================
  // Second pass over the other dimension
  logic [7:0] p2_q;
  logic rb_q;
  logic [3:0] a2;
  logic [3:0] c2;
  logic signed [20:0] t_rd;
  logic signed [39:0] acc2_q [16];
  logic signed [39:0] sum2 [16];
  logic signed [39:0] hold_q [16];
  logic [3:0] hold_u_q;
  logic [3:0] ser_q;

  assign a2 = 4'(p2_q >> l2);
  assign c2 = p2_q[3:0] & l2_m1;
  assign t_rd = tmem[{rb_q, a2, c2}];

  for (genvar v = 0; v < 16; v++) begin : g_s2
    logic signed [13:0] c;
    logic signed [34:0] prod;
    assign c = dctc_cos(dctc_ang(cfg_q.fwd, 4'(v), c2, l2));
    assign prod = t_rd * c;
    assign sum2[v] = (c2 == 4'h0 ? 40'sh0 : acc2_q[v]) + 40'(prod);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s2_run_q <= 1'b0;
      p2_q <= 8'h00;
      rb_q <= 1'b0;
    end else if (run) begin
      if (p1_q == mn_m1) begin
        s2_run_q <= 1'b1;
        p2_q <= 8'h00;
        rb_q <= wb_q;
      end else if (s2_run_q) begin
        s2_run_q <= (p2_q != mn_m1);
        p2_q <= p2_q + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int v = 0; v < 16; v++) acc2_q[v] <= 40'sh0;
      for (int v = 0; v < 16; v++) hold_q[v] <= 40'sh0;
      hold_u_q <= 4'h0;
      ser_run_q <= 1'b0;
      ser_q <= 4'h0;
    end else if (run) begin
      for (int v = 0; v < 16; v++) acc2_q[v] <= sum2[v];
      if (s2_run_q && c2 == l2_m1) begin
        for (int v = 0; v < 16; v++) hold_q[v] <= sum2[v];
        hold_u_q <= a2;
        ser_run_q <= 1'b1;
        ser_q <= 4'h0;
      end else if (ser_run_q) begin
        ser_run_q <= (ser_q != l2_m1);
        ser_q <= ser_q + 4'h1; // [RULE_05]
      end
    end
  end

  // ==========================================================
  // Scaling, rounding and saturation
  logic [4:0] sh;
  logic signed [39:0] rnd;
  logic signed [39:0] lim_hi;
  logic signed [39:0] lim_lo;
  logic signed [11:0] res_d;
  logic signed [11:0] res_q;

  always_comb begin
    sh = cfg_q.fwd ? 5'(DCTC_FWD_SH_BASE + {2'h0, geo.lm} + {2'h0, geo.ln}
                        + {4'h0, hold_u_q == 4'h0} + {4'h0, ser_q == 4'h0})
                   : DCTC_INV_SH; // [RULE_06]
    rnd = (hold_q[ser_q] + (40'sh1 <<< (sh - 5'h01))) >>> sh; // [RULE_06]
    lim_hi = 40'(DCTC_COEF_MAX);
    lim_lo = 40'(DCTC_COEF_MIN); // [RULE_02]
    if (!cfg_q.fwd) begin
      lim_hi = 40'(DCTC_PIX_MAX);
      lim_lo = cfg_q.range_sel ? 40'(DCTC_UPIX_MIN) : 40'(DCTC_PIX_MIN); // [RULE_09] [RULE_03]
    end
    if (rnd > lim_hi) begin
      res_d = 12'(lim_hi);
    end else if (rnd < lim_lo) begin
      res_d = 12'(lim_lo);
    end else begin
      res_d = 12'(rnd);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_q <= 12'sh000;
    end else if (run) begin
      res_q <= ser_run_q ? res_d : 12'sh000;
    end
  end

  // ==========================================================
  // Latency alignment and pins
  logic [11:0] dly_data;
  logic dly_stb;

  dctc_delay #(.W(12), .AW(7)) u_data_dly (
    .clk(hclk),
    .rst_n(hresetn),
    .adv(run),
    .wr_data(res_q),
    .ofs(7'(8'(DCTC_DATA_OFS_BASE) - (8'h01 << l2))), // [RULE_13]
    .rd_data(dly_data)
  );

  dctc_delay #(.W(1), .AW(9)) u_stb_dly (
    .clk(hclk),
    .rst_n(hresetn),
    .adv(run),
    .wr_data(stb_q),
    .ofs(9'(mn + 9'(DCTC_STB_OFS_BASE))), // [RULE_13]
    .rd_data(dly_stb)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coef_bus_oe <= DCTC_CFG_RST.fwd;
      coef_block_strobe_n_oe <= DCTC_CFG_RST.fwd;
      pixel_bus_oe <= ~DCTC_CFG_RST.fwd;
      pixel_block_strobe_n_oe <= ~DCTC_CFG_RST.fwd;
    end else begin
      coef_bus_oe <= cfg_q.fwd; // [RULE_01]
      coef_block_strobe_n_oe <= cfg_q.fwd; // [RULE_14]
      pixel_bus_oe <= ~cfg_q.fwd;
      pixel_block_strobe_n_oe <= ~cfg_q.fwd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coef_bus_out <= 12'h000;
      pixel_bus_out <= 9'h000;
      coef_block_strobe_n_out <= 1'b1;
      pixel_block_strobe_n_out <= 1'b1;
    end else if (run) begin
      coef_bus_out <= cfg_q.fwd ? dly_data : 12'h000; // [RULE_01]
      pixel_bus_out <= cfg_q.fwd ? 9'h000 : dly_data[8:0];
      coef_block_strobe_n_out <= ~(cfg_q.fwd & dly_stb); // [RULE_14]
      pixel_block_strobe_n_out <= ~(~cfg_q.fwd & dly_stb);
    end
  end

  // ==========================================================
  // Checks
  logic [9:0] lat_cnt_q;
  logic lat_on_q;
  logic [9:0] lat_tgt;

  assign lat_tgt = 10'(mn) + 10'(DCTC_LAT_BASE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_cnt_q <= 10'h000;
      lat_on_q <= 1'b0;
    end else if (run) begin
      if (!lat_on_q && stb_q) begin
        lat_on_q <= 1'b1;
        lat_cnt_q <= 10'h002;
      end else if (lat_on_q) begin
        lat_cnt_q <= lat_cnt_q + 10'h001;
        lat_on_q <= (lat_cnt_q != lat_tgt);
      end
    end
  end

  sequence s_group_done;
    run && s2_run_q && c2 == l2_m1;
  endsequence

  sequence s_ser_start;
    ser_run_q && ser_q == 4'h0;
  endsequence

  a_dir_oe: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
    coef_bus_oe == $past(cfg_q.fwd) && pixel_bus_oe == !coef_bus_oe)
    else $error("bus direction does not follow direction select");

  a_geom_range: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_04]
    geo.lm >= 3'h2 && geo.lm <= 3'h4 && geo.ln >= 3'h2 && geo.ln <= 3'h4)
    else $error("block geometry out of supported set");

  a_fwd_clip: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
    (run && cfg_q.fwd && !cfg_q.range_sel) |=> (in_q >= -12'sd128 && in_q <= 12'sd127))
    else $error("signed pixel input not clipped");

  a_unsigned_sat: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_09]
    (run && ser_run_q && !cfg_q.fwd && cfg_q.range_sel) |=> (res_q >= 12'sd0 && res_q <= 12'sd255))
    else $error("inverse pixel not saturated to unsigned range");

  a_strobe_lat: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_13]
    (run && lat_on_q && lat_cnt_q == lat_tgt) |->
      (cfg_q.fwd ? !coef_block_strobe_n_out : !pixel_block_strobe_n_out))
    else $error("output strobe latency wrong");

  a_freeze_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
    cfg_q.freeze |=> $stable(p1_q) && $stable(res_q) && $stable(coef_bus_out))
    else $error("state moved while frozen");

  a_pos_step: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_12]
    (run && !stb_sel && p1_q != mn_m1) |=> p1_q == 8'($past(p1_q) + 8'h01))
    else $error("input position did not advance one per clock");

  a_ser_order: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_05]
    s_group_done |=> s_ser_start ##1 (!$past(run) || ser_q == 4'h1 || !ser_run_q))
    else $error("transposed output group did not start in order");

  a_strobe_dir: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
    coef_block_strobe_n_oe == coef_bus_oe && pixel_block_strobe_n_oe == pixel_bus_oe)
    else $error("strobe direction differs from bus direction");

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");

endmodule

// file: dctc_delay.sv
`timescale 1ns/1ps
module dctc_delay #(
  parameter int W = 12,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adv,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] ofs,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [2**AW];
  logic [AW-1:0] wp_q;
  logic [AW:0] fill_q;

  // ==========================================================
  // Circular store
  always_ff @(posedge clk) begin
    if (adv) begin
      mem[wp_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      fill_q <= '0;
    end else if (adv) begin
      wp_q <= wp_q + 1'b1;
      if (!fill_q[AW]) begin
        fill_q <= fill_q + 1'b1;
      end
    end
  end

  // Unwritten slots read as zero
  assign rd_data = (fill_q >= {1'b0, ofs}) ? mem[AW'(wp_q - ofs)] : '0;

  a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
    adv |=> wp_q == AW'($past(wp_q) + 1'b1))
    else $error("delay pointer did not advance");

endmodule

// file: dctc_feed_model.sv
`timescale 1ns/1ps
// ==========================================================
// Upstream feeder, one item per clock
module dctc_feed_model (
  input wire logic hclk,
  output logic [11:0] item = 12'h000,
  output logic stb_n = 1'b1
);
  int q[$];
  int len = 16;
  int k = 0;
  logic [11:0] junk_q = 12'hA5C;
  always @(posedge hclk) begin
    junk_q <= {junk_q[10:0], junk_q[11] ^ junk_q[6]};
    if (q.size() > 0) begin
      item <= 12'(q.pop_front());
      stb_n <= (k % len) != 0;
      k++;
    end else begin
      // Idle bus keeps changing
      item <= junk_q;
      stb_n <= 1'b1;
    end
  end
  task automatic send(input int v[$], input int n);
    @(negedge hclk);
    len = n;
    k = 0;
    q = v;
  endtask
endmodule

// file: dctc_pkg.sv
package dctc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned DCTC_CLK_HZ = 40_000_000;
  localparam int unsigned DCTC_LAT_BASE = 130;
  localparam int unsigned DCTC_DATA_OFS_BASE = DCTC_LAT_BASE - 3;
  localparam int unsigned DCTC_STB_OFS_BASE = DCTC_LAT_BASE - 2;

  // ==========================================================
  // Register map
  localparam logic [7:0] DCTC_CTRL_OFS = 8'h00;
  localparam logic [7:0] DCTC_STAT_OFS = 8'h04;
  localparam int DCTC_FWD_BIT = 0;
  localparam int DCTC_BSIZE_LSB = 1;
  localparam int DCTC_RANGE_BIT = 4;
  localparam int DCTC_FREEZE_BIT = 5;
  localparam int DCTC_ST_POS_LSB = 0;
  localparam int DCTC_ST_S2_BIT = 8;
  localparam int DCTC_ST_OUT_BIT = 9;

  // ==========================================================
  // Number formats
  localparam int DCTC_PIX_W = 9;
  localparam int DCTC_COEF_W = 12;
  localparam int DCTC_T_SHIFT = 8;
  localparam logic [4:0] DCTC_FWD_SH_BASE = 5'h0B;
  localparam logic [4:0] DCTC_INV_SH = 5'h13;
  localparam logic signed [8:0] DCTC_SCLIP_LO = 9'h180;
  localparam logic signed [8:0] DCTC_SCLIP_HI = 9'h07F;
  localparam logic signed [11:0] DCTC_COEF_MAX = 12'h7FF;
  localparam logic signed [11:0] DCTC_COEF_MIN = 12'h800;
  localparam logic signed [11:0] DCTC_PIX_MAX = 12'h0FF;
  localparam logic signed [11:0] DCTC_PIX_MIN = 12'hF00;
  localparam logic signed [11:0] DCTC_UPIX_MIN = 12'h000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic fwd;
    logic [2:0] bsize;
    logic range_sel;
    logic freeze;
  } dctc_cfg_t;

  typedef struct packed {
    logic [2:0] lm;
    logic [2:0] ln;
  } dctc_geom_t;

  localparam dctc_cfg_t DCTC_CFG_RST = '{fwd: 1'b1, bsize: 3'h6, range_sel: 1'b0, freeze: 1'b0};

  // ==========================================================
  // Functions
  function automatic dctc_cfg_t dctc_ctrl_unpack(input logic [31:0] w);
    dctc_cfg_t c;
    c.fwd = w[DCTC_FWD_BIT];
    c.bsize = w[DCTC_BSIZE_LSB +: 3];
    c.range_sel = w[DCTC_RANGE_BIT];
    c.freeze = w[DCTC_FREEZE_BIT];
    return c;
  endfunction

  // Code value is {bit2, bit1, bit0}; log2 of lines and columns
  function automatic dctc_geom_t dctc_geom(input logic [2:0] bs);
    dctc_geom_t g;
    unique case (bs)
      3'h0: g = '{lm: 3'h4, ln: 3'h4};
      3'h4: g = '{lm: 3'h3, ln: 3'h4};
      3'h2: g = '{lm: 3'h4, ln: 3'h3};
      3'h6: g = '{lm: 3'h3, ln: 3'h3};
      3'h1: g = '{lm: 3'h2, ln: 3'h3};
      3'h5: g = '{lm: 3'h3, ln: 3'h2};
      3'h3: g = '{lm: 3'h2, ln: 3'h2};
      3'h7: g = '{lm: 3'h3, ln: 3'h3};
    endcase
    return g;
  endfunction

  // Cosine angle in units of pi/32, modulo 2pi
  function automatic logic [5:0] dctc_ang(input logic fwd, input logic [3:0] acc,
                                          input logic [3:0] inp, input logic [2:0] l);
    logic [11:0] t;
    t = fwd ? 12'({inp, 1'b1}) * 12'(acc) : 12'({acc, 1'b1}) * 12'(inp);
    t = t << (3'h4 - l);
    return t[5:0];
  endfunction

  // Cosine in Q12
  function automatic logic signed [13:0] dctc_cos(input logic [5:0] k);
    logic [4:0] q;
    logic neg;
    logic [12:0] m;
    q = 5'h00;
    neg = 1'b0;
    m = 13'h0000;
    if (k <= 6'h10) begin
      q = k[4:0];
    end else if (k <= 6'h20) begin
      q = 5'(6'h20 - k);
      neg = 1'b1;
    end else if (k <= 6'h30) begin
      q = 5'(k - 6'h20);
      neg = 1'b1;
    end else begin
      q = 5'(7'h40 - {1'b0, k});
    end
    unique case (q)
      5'h00: m = 13'h1000;
      5'h01: m = 13'h0FEC;
      5'h02: m = 13'h0FB1;
      5'h03: m = 13'h0F50;
      5'h04: m = 13'h0EC8;
      5'h05: m = 13'h0E1C;
      5'h06: m = 13'h0D4E;
      5'h07: m = 13'h0C5E;
      5'h08: m = 13'h0B50;
      5'h09: m = 13'h0A26;
      5'h0A: m = 13'h08E4;
      5'h0B: m = 13'h078B;
      5'h0C: m = 13'h061F;
      5'h0D: m = 13'h04A5;
      5'h0E: m = 13'h031F;
      5'h0F: m = 13'h0191;
      default: m = 13'h0000;
    endcase
    return neg ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

endpackage
